// ### rtl/epm_monitor.sv
// engine protection monitor: thresholds, contacts, battery, service hours
//
// What this block does
// - contact high coolant needs an input with the coolant function code and nonzero delay
// - zero contact delay disables every contact protection on that input
// - engine checks only while fuel command on, never during start or stop
// - temperature conditions ignored until mask time after engine start elapsed
// - contact protection fires only after uninterrupted activity for whole delay
// - temperature from analogue input, or from can link when engine type nonzero
// - coolant at or above high threshold for its delay gives warning
// - coolant at or above maximum threshold for its delay gives alarm
// - oil temperature at or above threshold for its delay gives alarm
// - each analogue protection disabled when its delay is zero
// - contact maximum coolant is an alarm with same gating as contact high
// - low battery protection active except while cranking
// - battery strictly below low threshold for its delay gives warning
// - battery strictly above high threshold for its delay warns, not while cranking
// - battery thresholds are percent of automatically chosen rated voltage
// - rated voltage chosen at power-up and off-reset entry: 12 V up to 17 V
// - service event after interval hours, acting as warning, block or deactivation
// - service event survives supply loss, cleared only by rewriting interval
// - engine hours counted whenever engine runs, whoever started it
// - service interval and action writable only at installer access
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module epm_monitor #(
    parameter int unsigned SEC_CYCLES_P = epm_pkg::SEC_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire epm_pkg::epm_eng_t eng,
    input wire epm_pkg::epm_meas_t ana_meas,
    input wire epm_pkg::epm_meas_t can_meas,
    input wire logic [15:0] vbat_dv,
    input wire logic off_reset,
    input wire logic [epm_pkg::DIN_COUNT-1:0] din,
    input wire logic nv_restore,
    input wire epm_pkg::epm_svc_nv_t nv_svc,
    output epm_pkg::epm_svc_nv_t svc_state,
    output epm_pkg::epm_prot_t prot,
    output logic rated_24v,
    output logic svc_warn,
    output logic svc_block,
    output logic svc_deact
);
    import epm_pkg::*;

    function automatic logic [31:0] pct_scale(input logic [15:0] a, input logic [15:0] b);
        pct_scale = 32'(a) * 32'(b);
    endfunction : pct_scale
    function automatic logic [15:0] hi_field(input logic [31:0] w);
        hi_field = w[FLD_HI_LSB +: FLD_W];
    endfunction : hi_field
    function automatic logic [15:0] lo_field(input logic [31:0] w);
        lo_field = w[FLD_LO_LSB +: FLD_W];
    endfunction : lo_field

    // ---- register state
    logic access_installer;
    logic [15:0] mask_time;
    logic [31:0] din_cfg [DIN_COUNT];
    logic [31:0] cool_high_cfg;
    logic [31:0] cool_max_cfg;
    logic [31:0] oil_max_cfg;
    logic [31:0] bat_low_cfg;
    logic [31:0] bat_high_cfg;
    logic [31:0] src_cfg;
    logic [15:0] svc_interval;
    logic [1:0] svc_action;
    logic [31:0] hours_total;
    logic [15:0] svc_elapsed;
    logic svc_event;

    // ---- ahb-lite slave, zero-wait writes, one-wait reads
    epm_bus_st_t bus_st;
    logic wr_pend;
    logic [7:0] wr_addr, rd_addr;
    wire take = hsel & hready & (htrans == HTRANS_NONSEQ);
    wire take_rd = take & ~hwrite;
    wire take_wr = take & hwrite;
    wire [7:0] wr_ofs = wr_addr;
    wire is_din_wr = wr_pend & (wr_ofs >= OFS_DIN_CFG0) & (wr_ofs < OFS_COOL_HIGH);
    wire [1:0] din_wr_idx = 2'((wr_ofs - OFS_DIN_CFG0) >> 2);
    wire installer_ok = access_installer;
    wire svc_int_wr = wr_pend & (wr_ofs == OFS_SVC_INTERVAL) & installer_ok;
    wire svc_act_wr = wr_pend & (wr_ofs == OFS_SVC_ACTION) & installer_ok;

    assign hreadyout = (bus_st == BUS_IDLE);
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_st <= BUS_IDLE;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            rd_addr <= 8'h00;
        end else begin
            wr_pend <= take_wr;
            if (take_wr) begin
                wr_addr <= haddr[7:0];
            end
            if (take_rd) begin
                rd_addr <= haddr[7:0];
            end
            unique case (bus_st)
                BUS_IDLE: bus_st <= take_rd ? BUS_RD_WAIT : BUS_IDLE;
                BUS_RD_WAIT: bus_st <= BUS_IDLE;
            endcase
        end
    end

    logic [31:0] rd_mux;
    // the wait state lets a write just before a read land first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= RESET_WORD;
        end else if (bus_st == BUS_RD_WAIT) begin
            hrdata <= rd_mux;
        end
    end
    wire [31:0] status_word = {23'h000000, rated_24v, svc_event, prot};
    wire [1:0] din_rd_idx = 2'((rd_addr - OFS_DIN_CFG0) >> 2);
    wire rd_is_din = (rd_addr >= OFS_DIN_CFG0) & (rd_addr < OFS_COOL_HIGH);
    always_comb begin
        rd_mux = RESET_WORD;
        if (rd_is_din) begin
            rd_mux = din_cfg[din_rd_idx];
        end else begin
            case (rd_addr)
                OFS_ACCESS: rd_mux = {31'h00000000, access_installer};
                OFS_MASK_TIME: rd_mux = {16'h0000, mask_time};
                OFS_COOL_HIGH: rd_mux = cool_high_cfg;
                OFS_COOL_MAX: rd_mux = cool_max_cfg;
                OFS_OIL_MAX: rd_mux = oil_max_cfg;
                OFS_BAT_LOW: rd_mux = bat_low_cfg;
                OFS_BAT_HIGH: rd_mux = bat_high_cfg;
                OFS_SRC_CFG: rd_mux = src_cfg;
                OFS_SVC_INTERVAL: rd_mux = {16'h0000, svc_interval};
                OFS_SVC_ACTION: rd_mux = {30'h00000000, svc_action};
                OFS_STATUS: rd_mux = status_word;
                OFS_HOURS: rd_mux = hours_total;
                OFS_SVC_ELAPSED: rd_mux = {16'h0000, svc_elapsed};
                default: rd_mux = RESET_WORD;
            endcase
        end
    end

    // configuration writes; unmapped offsets are ignored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            access_installer <= 1'b0;
            mask_time <= 16'h0000;
            for (int i = 0; i < DIN_COUNT; i++) begin
                din_cfg[i] <= RESET_WORD;
            end
            cool_high_cfg <= RESET_WORD;
            cool_max_cfg <= RESET_WORD;
            oil_max_cfg <= RESET_WORD;
            bat_low_cfg <= RESET_WORD;
            bat_high_cfg <= RESET_WORD;
            src_cfg <= RESET_WORD;
        end else if (wr_pend) begin
            if (is_din_wr) begin
                din_cfg[din_wr_idx] <= hwdata;
            end
            case (wr_ofs)
                OFS_ACCESS: access_installer <= hwdata[ACCESS_INSTALLER_BIT];
                OFS_MASK_TIME: mask_time <= lo_field(hwdata);
                OFS_COOL_HIGH: cool_high_cfg <= hwdata;
                OFS_COOL_MAX: cool_max_cfg <= hwdata;
                OFS_OIL_MAX: oil_max_cfg <= hwdata;
                OFS_BAT_LOW: bat_low_cfg <= hwdata;
                OFS_BAT_HIGH: bat_high_cfg <= hwdata;
                OFS_SRC_CFG: src_cfg <= hwdata;
                default: ;
            endcase
        end
    end

    // ---- one-second enable and engine hour tick
    logic [31:0] div_cnt;
    wire sec_tick = (div_cnt == 32'(SEC_CYCLES_P - 1));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt <= 32'h0000_0000;
        end else begin
            div_cnt <= sec_tick ? 32'h0000_0000 : div_cnt + 32'h0000_0001;
        end
    end

    logic [11:0] sec_in_hour;
    wire run_sec = sec_tick & eng.running;
    wire hour_tick = run_sec & (sec_in_hour == 12'(HOUR_S - 1));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sec_in_hour <= 12'h000;
            hours_total <= 32'h0000_0000;
        end else if (run_sec) begin
            sec_in_hour <= hour_tick ? 12'h000 : sec_in_hour + 12'h001;
            if (hour_tick) begin
                hours_total <= hours_total + 32'h0000_0001;
            end
        end
    end

    // ---- engine gating and protection mask
    wire eng_ok = eng.fuel_cmd & ~eng.starting & ~eng.stopping;
    logic [15:0] mask_cnt;
    wire mask_done = eng.running & (mask_cnt >= mask_time);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_cnt <= 16'h0000;
        end else if (!eng.running) begin
            mask_cnt <= 16'h0000;
        end else if (sec_tick && !mask_done) begin
            mask_cnt <= mask_cnt + 16'h0001;
        end
    end
    wire eng_prot_en = eng_ok & mask_done;

    // ---- temperature source
    wire can_src = (src_cfg[SRC_ENGINE_TYPE_W-1:0] != 8'h00);
    wire cool_avail = can_src | src_cfg[SRC_COOL_ANA_BIT];
    wire oil_avail = can_src | src_cfg[SRC_OIL_ANA_BIT];
    wire signed [15:0] cool_t = can_src ? can_meas.coolant : ana_meas.coolant;
    wire signed [15:0] oil_t = can_src ? can_meas.oil : ana_meas.oil;
    wire cool_high_c = cool_t >= $signed(lo_field(cool_high_cfg));
    wire cool_max_c = cool_t >= $signed(lo_field(cool_max_cfg));
    wire oil_max_c = oil_t >= $signed(lo_field(oil_max_cfg));

    // ---- rated battery voltage, chosen after reset release and off-reset entry
    logic sel_pending, off_reset_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_pending <= 1'b1;
            off_reset_q <= 1'b0;
            rated_24v <= 1'b0;
        end else begin
            off_reset_q <= off_reset;
            sel_pending <= 1'b0;
            if (sel_pending || (off_reset && !off_reset_q)) begin
                rated_24v <= (vbat_dv > RATED_SEL_LIMIT_DV);
            end
        end
    end
    wire [15:0] rated_dv = rated_24v ? RATED_24V_DV : RATED_12V_DV;
    // compare in percent units so no division is needed
    wire [31:0] vbat_pct = pct_scale(vbat_dv, PCT_FULL);
    wire bat_low_c = vbat_pct < pct_scale(lo_field(bat_low_cfg), rated_dv);
    wire bat_high_c = vbat_pct > pct_scale(lo_field(bat_high_cfg), rated_dv);
    wire bat_en = ~eng.cranking;

    // ---- analogue protections; zero delay disables inside the timer
    logic f_cool_high, f_cool_max, f_oil_max, f_bat_low, f_bat_high;
    epm_delay_timer u_cool_high (
        .hclk(hclk), .hresetn(hresetn), .sec_tick(sec_tick),
        .enable(eng_prot_en & cool_avail), .cond(cool_high_c),
        .delay(hi_field(cool_high_cfg)), .fired(f_cool_high)
    );
    epm_delay_timer u_cool_max (
        .hclk(hclk), .hresetn(hresetn), .sec_tick(sec_tick),
        .enable(eng_prot_en & cool_avail), .cond(cool_max_c),
        .delay(hi_field(cool_max_cfg)), .fired(f_cool_max)
    );
    epm_delay_timer u_oil_max (
        .hclk(hclk), .hresetn(hresetn), .sec_tick(sec_tick),
        .enable(eng_prot_en & oil_avail), .cond(oil_max_c),
        .delay(hi_field(oil_max_cfg)), .fired(f_oil_max)
    );
    epm_delay_timer u_bat_low (
        .hclk(hclk), .hresetn(hresetn), .sec_tick(sec_tick),
        .enable(bat_en), .cond(bat_low_c),
        .delay(hi_field(bat_low_cfg)), .fired(f_bat_low)
    );
    epm_delay_timer u_bat_high (
        .hclk(hclk), .hresetn(hresetn), .sec_tick(sec_tick),
        .enable(bat_en), .cond(bat_high_c),
        .delay(hi_field(bat_high_cfg)), .fired(f_bat_high)
    );
    // ---- contact protections, one timer per input
    logic [DIN_COUNT-1:0] din_fired, din_is_high, din_is_max;
    for (genvar g = 0; g < DIN_COUNT; g++) begin : g_din
        assign din_is_high[g] = (lo_field(din_cfg[g]) == COOLANT_CONTACT_FUNCTION_CODE);
        assign din_is_max[g] = (lo_field(din_cfg[g]) == COOLANT_MAX_CONTACT_FUNCTION_CODE);
        epm_delay_timer u_din (
            .hclk(hclk), .hresetn(hresetn), .sec_tick(sec_tick),
            .enable(eng_prot_en & (din_is_high[g] | din_is_max[g])),
            .cond(din[g]),
            .delay(hi_field(din_cfg[g])),
            .fired(din_fired[g])
        );
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prot <= '0;
        end else begin
            prot.cool_high_warn <= f_cool_high;
            prot.cool_max_alarm <= f_cool_max;
            prot.oil_max_alarm <= f_oil_max;
            prot.bat_low_warn <= f_bat_low;
            prot.bat_high_warn <= f_bat_high;
            prot.ccool_high_warn <= |(din_fired & din_is_high);
            prot.ccool_max_alarm <= |(din_fired & din_is_max);
        end
    end

    // ---- service interval; state is restored from non-volatile storage
    wire svc_reached = (svc_interval != 16'h0000) & (svc_elapsed >= svc_interval);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            svc_interval <= 16'h0000;
            svc_action <= SVC_ACT_WARN;
            svc_elapsed <= 16'h0000;
            svc_event <= 1'b0;
        end else if (nv_restore) begin
            svc_interval <= nv_svc.interval;
            svc_action <= nv_svc.action;
            svc_elapsed <= nv_svc.elapsed;
            svc_event <= nv_svc.event_active;
        end else begin
            if (svc_act_wr) begin
                svc_action <= hwdata[1:0];
            end
            if (svc_int_wr) begin
                svc_interval <= lo_field(hwdata);
                svc_elapsed <= 16'h0000;
            end else if (hour_tick && svc_elapsed != 16'hFFFF) begin
                svc_elapsed <= svc_elapsed + 16'h0001;
            end
            // a rewrite restarts the count, so a reach seen with old values is stale
            if (svc_int_wr) begin
                svc_event <= 1'b0;
            end else if (svc_reached) begin
                svc_event <= 1'b1;
            end
        end
    end
    assign svc_state = '{interval: svc_interval, action: svc_action,
                         elapsed: svc_elapsed, event_active: svc_event};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            svc_warn <= 1'b0;
            svc_block <= 1'b0;
            svc_deact <= 1'b0;
        end else begin
            svc_warn <= svc_event & (svc_action == SVC_ACT_WARN);
            svc_block <= svc_event & (svc_action == SVC_ACT_BLOCK);
            svc_deact <= svc_event & (svc_action == SVC_ACT_DEACT);
        end
    end

    // hsize is accepted but only whole words are meaningful
    wire unused_ok = ^{hsize, haddr[31:8]};
endmodule : epm_monitor
`default_nettype wire

// ### rtl/epm_pkg.sv
// constants, offsets and carrier types of the engine protection monitor
package epm_pkg;
    // time base
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned SECOND_NS = 1_000_000_000;
    localparam int unsigned SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;
    localparam int unsigned HOUR_S = 3600;
    // register byte offsets
    localparam logic [7:0] OFS_ACCESS = 8'h00;
    localparam logic [7:0] OFS_MASK_TIME = 8'h04;
    localparam logic [7:0] OFS_DIN_CFG0 = 8'h08;
    localparam logic [7:0] OFS_COOL_HIGH = 8'h18;
    localparam logic [7:0] OFS_COOL_MAX = 8'h1C;
    localparam logic [7:0] OFS_OIL_MAX = 8'h20;
    localparam logic [7:0] OFS_BAT_LOW = 8'h24;
    localparam logic [7:0] OFS_BAT_HIGH = 8'h28;
    localparam logic [7:0] OFS_SRC_CFG = 8'h2C;
    localparam logic [7:0] OFS_SVC_INTERVAL = 8'h30;
    localparam logic [7:0] OFS_SVC_ACTION = 8'h34;
    localparam logic [7:0] OFS_STATUS = 8'h38;
    localparam logic [7:0] OFS_HOURS = 8'h3C;
    localparam logic [7:0] OFS_SVC_ELAPSED = 8'h40;
    // contact inputs
    localparam int DIN_COUNT = 4;
    localparam logic [15:0] COOLANT_CONTACT_FUNCTION_CODE = 16'h1087;
    localparam logic [15:0] COOLANT_MAX_CONTACT_FUNCTION_CODE = 16'h1087;
    // field positions
    localparam int FLD_LO_LSB = 0;
    localparam int FLD_HI_LSB = 16;
    localparam int FLD_W = 16;
    localparam int SRC_ENGINE_TYPE_W = 8;
    localparam int SRC_COOL_ANA_BIT = 8;
    localparam int SRC_OIL_ANA_BIT = 9;
    localparam int ACCESS_INSTALLER_BIT = 0;
    // battery, in tenths of a volt, and the percent full scale
    localparam logic [15:0] RATED_12V_DV = 16'h0078;
    localparam logic [15:0] RATED_24V_DV = 16'h00F0;
    localparam logic [15:0] RATED_SEL_LIMIT_DV = 16'h00AA;
    localparam logic [15:0] PCT_FULL = 16'h0064;
    // service action codes
    localparam logic [1:0] SVC_ACT_WARN = 2'h0;
    localparam logic [1:0] SVC_ACT_BLOCK = 2'h1;
    localparam logic [1:0] SVC_ACT_DEACT = 2'h2;
    // ahb
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef struct packed {
        logic signed [15:0] coolant;
        logic signed [15:0] oil;
    } epm_meas_t;

    typedef struct packed {
        logic fuel_cmd;
        logic starting;
        logic stopping;
        logic cranking;
        logic running;
    } epm_eng_t;

    typedef struct packed {
        logic ccool_max_alarm;
        logic ccool_high_warn;
        logic bat_high_warn;
        logic bat_low_warn;
        logic oil_max_alarm;
        logic cool_max_alarm;
        logic cool_high_warn;
    } epm_prot_t;

    typedef struct packed {
        logic [15:0] interval;
        logic [1:0] action;
        logic [15:0] elapsed;
        logic event_active;
    } epm_svc_nv_t;

    typedef enum logic {BUS_IDLE, BUS_RD_WAIT} epm_bus_st_t;
endpackage : epm_pkg

// ### rtl/epm_delay_timer.sv
// continuous-condition delay timer counted in whole seconds
`timescale 1ns/1ps
`default_nettype none
module epm_delay_timer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic sec_tick,
    input wire logic enable,
    input wire logic cond,
    input wire logic [15:0] delay,
    output logic fired
);
    import epm_pkg::*;

    logic [15:0] count;
    wire armed = enable & cond & (delay != 16'h0000);
    wire at_end = (count >= delay);

    // any drop of cause or enable restarts from zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= 16'h0000;
        end else if (!armed) begin
            count <= 16'h0000;
        end else if (sec_tick && !at_end) begin
            count <= count + 16'h0001;
        end
    end

    assign fired = armed & at_end;
endmodule : epm_delay_timer
`default_nettype wire

// ### verif/epm_engine_model.sv
// sensor, contact and engine-state front end facing the monitor
`timescale 1ns/1ps
`default_nettype none
module epm_engine_model (
    input wire logic hclk,
    input wire epm_pkg::epm_eng_t eng_set,
    input wire epm_pkg::epm_meas_t ana_set,
    input wire epm_pkg::epm_meas_t can_set,
    input wire logic [15:0] vbat_set,
    input wire logic [epm_pkg::DIN_COUNT-1:0] din_set,
    output epm_pkg::epm_eng_t eng,
    output epm_pkg::epm_meas_t ana_meas,
    output epm_pkg::epm_meas_t can_meas,
    output logic [15:0] vbat_dv,
    output logic [epm_pkg::DIN_COUNT-1:0] din
);
    import epm_pkg::*;
    initial begin
        eng = '0;
        ana_meas = '0;
        can_meas = '0;
        vbat_dv = 16'h0000;
        din = '0;
    end
    // sampled front end: values settle one clock after the request
    always @(posedge hclk) begin
        eng <= eng_set;
        ana_meas <= ana_set;
        can_meas <= can_set;
        vbat_dv <= vbat_set;
        din <= din_set;
    end
endmodule : epm_engine_model
`default_nettype wire

// ### verif/epm_monitor_props.sv
// bus and gating assertions of the engine protection monitor
`timescale 1ns/1ps
`default_nettype none
module epm_monitor_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire epm_pkg::epm_eng_t eng,
    input wire epm_pkg::epm_svc_nv_t svc_state,
    input wire epm_pkg::epm_prot_t prot,
    input wire logic svc_warn,
    input wire logic svc_block,
    input wire logic svc_deact
);
    import epm_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic taken = hsel && hready && htrans == HTRANS_NONSEQ;
    wire logic any_svc = svc_warn || svc_block || svc_deact;
    wire logic [4:0] eng_prot = {prot.ccool_max_alarm, prot.ccool_high_warn,
        prot.oil_max_alarm, prot.cool_max_alarm, prot.cool_high_warn};
    sequence rd_taken; taken && !hwrite; endsequence
    sequence one_wait; !hreadyout ##1 hreadyout; endsequence
    okay_resp_a: assert property (hresp == 1'h0) else $error("response not okay");
    rd_one_wait_a: assert property (rd_taken |=> one_wait) else $error("read wait wrong");
    wr_no_wait_a: assert property (taken && hwrite |=> hreadyout) else $error("write stalled");
    phase_gate_a: assert property (eng.starting || eng.stopping |=> eng_prot == 5'h00)
        else $error("engine protection during start or stop");
    fuel_gate_a: assert property (!eng.fuel_cmd |=> eng_prot == 5'h00)
        else $error("engine protection without fuel command");
    crank_bat_a: assert property (eng.cranking |=> !prot.bat_low_warn && !prot.bat_high_warn)
        else $error("battery warning while cranking");
    contact_pair_a: assert property (prot.ccool_max_alarm == prot.ccool_high_warn)
        else $error("contact coolant pair differs");
    svc_onehot_a: assert property ($onehot0({svc_warn, svc_block, svc_deact}))
        else $error("several service actions");
    svc_cause_a: assert property (any_svc |-> $past(svc_state.event_active))
        else $error("service output without event");
    svc_block_a: assert property (svc_block |-> $past(svc_state.action) == SVC_ACT_BLOCK)
        else $error("block action mismatch");
endmodule : epm_monitor_props
bind epm_monitor epm_monitor_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .eng(eng), .svc_state(svc_state), .prot(prot), .svc_warn(svc_warn),
    .svc_block(svc_block), .svc_deact(svc_deact));
`default_nettype wire

// ### verif/tb.sv
// self-checking bench of the engine protection monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
    import epm_pkg::*;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0;
    logic off_reset = 1'h0;
    epm_eng_t eng_set = '0;
    epm_meas_t ana_set = '0;
    epm_meas_t can_set = '0;
    logic [15:0] vbat_set = 16'h0082;
    logic [DIN_COUNT-1:0] din_set = '0;
    wire logic [31:0] hrdata;
    wire logic hreadyout;
    wire logic rated_24v;
    wire logic svc_block;
    epm_eng_t eng;
    epm_meas_t ana_meas;
    epm_meas_t can_meas;
    epm_prot_t prot;
    logic [15:0] vbat_dv;
    logic [DIN_COUNT-1:0] din;
    int fails = 0;
    int cmp_count = 0;
    always #20 hclk = ~hclk;
    epm_engine_model u_eng (.hclk(hclk), .eng_set(eng_set), .ana_set(ana_set),
        .can_set(can_set), .vbat_set(vbat_set), .din_set(din_set), .eng(eng),
        .ana_meas(ana_meas), .can_meas(can_meas), .vbat_dv(vbat_dv), .din(din));
    // short second keeps the service hour inside the run
    epm_monitor #(.SEC_CYCLES_P(10)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .eng(eng), .ana_meas(ana_meas), .can_meas(can_meas), .vbat_dv(vbat_dv),
        .off_reset(off_reset), .din(din), .nv_restore(1'h0), .nv_svc('0), .svc_state(),
        .prot(prot), .rated_24v(rated_24v), .svc_warn(), .svc_block(svc_block), .svc_deact());
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic ahb(input logic [7:0] ofs, input logic wr, input logic [31:0] wd,
        output logic [31:0] rd);
        haddr <= {24'h000000, ofs};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask : ahb
    task automatic wr(input logic [7:0] ofs, input logic [31:0] wd);
        logic [31:0] d;
        ahb(ofs, 1'h1, wd, d);
    endtask : wr
    task automatic rdchk(input string name, input logic [7:0] ofs, input logic [31:0] exp);
        logic [31:0] d;
        ahb(ofs, 1'h0, 32'h0, d);
        chk(name, exp, d);
    endtask : rdchk
    task automatic rated(input logic [15:0] v, input logic exp);
        vbat_set <= v;
        tick(3);
        off_reset <= 1'h1;
        tick(3);
        off_reset <= 1'h0;
        tick(2);
        chk("rated", {31'h0, exp}, {31'h0, rated_24v});
    endtask : rated
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    initial begin
        repeat (45000) @(posedge hclk);
        fails++;
        complete_run();
    end
    initial begin
        tick(8);
        hresetn <= 1'h1;
        tick(3);
        chk("rated", 32'h0, {31'h0, rated_24v});
        rdchk("unmapped", 8'h80, 32'h0);
        rated(16'h00FA, 1'h1);
        rated(16'h00AA, 1'h0);
        wr(OFS_SVC_INTERVAL, 32'h1);
        rdchk("interval", OFS_SVC_INTERVAL, 32'h0);
        wr(OFS_ACCESS, 32'h1);
        wr(OFS_SVC_INTERVAL, 32'h1);
        wr(OFS_SVC_ACTION, {30'h0, SVC_ACT_BLOCK});
        // engine runs without own fuel command: hours still count
        eng_set <= 5'h01;
        wr(OFS_SRC_CFG, 32'h0000_0100);
        wr(OFS_COOL_HIGH, 32'h0002_0064);
        ana_set <= 32'h0064_0000;
        tick(40);
        chk("prot", 32'h00, {25'h0, prot});
        eng_set <= 5'h11;
        tick(40);
        chk("prot", 32'h01, {25'h0, prot});
        eng_set <= 5'h19;
        tick(3);
        chk("prot", 32'h00, {25'h0, prot});
        eng_set <= 5'h11;
        wr(OFS_SRC_CFG, 32'h0000_0101);
        can_set <= 32'h005A_0000;
        tick(40);
        chk("prot", 32'h00, {25'h0, prot});
        wr(OFS_MASK_TIME, 32'h6);
        can_set <= 32'h0064_0000;
        tick(40);
        chk("prot", 32'h00, {25'h0, prot});
        tick(80);
        chk("prot", 32'h01, {25'h0, prot});
        can_set <= 32'h0000_0000;
        wr(OFS_DIN_CFG0, 32'h0000_1087);
        din_set <= 4'h1;
        tick(40);
        chk("prot", 32'h00, {25'h0, prot});
        wr(OFS_DIN_CFG0, 32'h0002_1087);
        for (int i = 0; i < 4; i++) begin
            din_set <= 4'h0;
            tick(2);
            din_set <= 4'h1;
            tick(8);
        end
        chk("prot", 32'h00, {25'h0, prot});
        tick(40);
        chk("prot", 32'h60, {25'h0, prot});
        din_set <= 4'h0;
        wr(OFS_BAT_LOW, 32'h0001_0050);
        vbat_set <= 16'h0060;
        tick(30);
        chk("prot", 32'h00, {25'h0, prot});
        vbat_set <= 16'h005F;
        tick(30);
        chk("prot", 32'h08, {25'h0, prot});
        rdchk("status", OFS_STATUS, 32'h08);
        eng_set <= 5'h13;
        tick(3);
        chk("prot", 32'h00, {25'h0, prot});
        eng_set <= 5'h01;
        tick(36100);
        chk("svc_block", 32'h1, {31'h0, svc_block});
        rdchk("elapsed", OFS_SVC_ELAPSED, 32'h1);
        rdchk("hours", OFS_HOURS, 32'h1);
        wr(OFS_SVC_INTERVAL, 32'h1);
        tick(3);
        chk("svc_block", 32'h0, {31'h0, svc_block});
        complete_run();
    end
endmodule : tb
`default_nettype wire
